/* File: cpp_pkg.sv */
// package of the codec serial port: register map, config layout, timing
// assumes a 20 MHz REF_CLK and a 32-bit APB master
package cpp_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DLY = 8'h04;
  localparam logic [7:0] A_TX = 8'h08;
  localparam logic [7:0] A_RX = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  // timing: master bit clock half period in ns, period of REF_CLK in ns
  localparam int CLK_NS = 50;
  localparam int BCLK_HALF_NS = 250;
  localparam int HALF_CYC = BCLK_HALF_NS / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  // frame of 32 bit clocks, counter wraps by itself
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h1F;
  localparam logic [4:0] ZERO_BIT = 5'h00;
  localparam logic [4:0] ONE_BIT = 5'h01;
  localparam logic [4:0] W8 = 5'h08;
  localparam logic [4:0] W16 = 5'h10;
  localparam logic [4:0] LONG_FS = 5'h08;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;
  // configuration register layout, bit 0 is play
  typedef struct packed {
    logic en;
    logic master;
    logic long_fs;
    logic wide;
    logic dual_rate;
    logic two_codecs;
    logic dual_ch;
    logic spk_ch2;
    logic rec;
    logic play;
  } cpp_cfg_t;
  localparam int CFG_W = 10;
  localparam cpp_cfg_t CFG_RST = 10'h000;
  // data delays, d0 in low bits
  typedef struct packed {
    logic [4:0] d1;
    logic [4:0] d0;
  } cpp_dly_t;
  localparam cpp_dly_t DLY_RST = 10'h000;
  // port state, gray along off, sync, run
  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_SYNC = 2'b01,
    PS_RUN = 2'b11
  } cpp_state_t;
endpackage : cpp_pkg

/* File: cpp_top.sv */
// codec serial port: APB registers, frame timing, slots, sample FIFO
// assumes codec pins arrive asynchronous; one REF_CLK domain
// Overview of operation
// - master mode drives bit clock and frame syncs
// - short or long frame sync selectable
// - slot carries 8 or 16 bits
// - dual rate halves incoming bit clock
// - line always on channel 0
// - speaker on ch1 or ch2; ch2 mastered
// - control register selects all port options but the slot delays
// - slot delays relative to primary frame sync; ch2 delay relative to the free-running master frame count
// - recording sums channel 0 and the speaker channel (1 or 2)
// - playback sent on channel 0 and the speaker channel (1 or 2)
module cpp_fifo #(parameter int W = 16, parameter int D = 8) (
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] n_reg;
  logic wr, rd;
  assign in_ready = n_reg != (AW+1)'(D);
  assign out_valid = n_reg != '0;
  assign out_data = mem[rp_reg];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;
  // storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (wr) mem[wp_reg] <= in_data;
  end
  // pointers and level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      n_reg <= '0;
    end
    else
    begin
      if (wr) wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
      if (rd) rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
      n_reg <= n_reg + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule : cpp_fifo

module cpp_top import cpp_pkg::*; (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // line bit clock and primary frame sync, two-way
  input wire logic BCLK_IN,
  output logic BCLK_OUT,
  output logic BCLK_OE,
  input wire logic PRIMARY_FRAME_SYNC_IN,
  output logic PRIMARY_FRAME_SYNC_OUT,
  output logic PRIMARY_FRAME_SYNC_OE,
  // line data, channels 0 and 1
  input wire logic DR_IN,
  output logic DX_OUT,
  output logic DX_OE,
  // channel 2 codec, always mastered here
  input wire logic DR2_IN,
  output logic FS2_OUT,
  output logic DX2_OUT,
  output logic DX2_OE
);
  // offset minus delay, wraps around the frame
  function automatic logic [4:0] pos(input logic [4:0] c, input logic [4:0] d);
    pos = c - d;
  endfunction : pos
  function automatic logic in_slot(input logic [4:0] o, input logic wide);
    in_slot = o < (wide ? W16 : W8);
  endfunction : in_slot
  function automatic logic fs_on(input logic [4:0] c, input logic [4:0] d,
                                 input logic lng);
    fs_on = lng ? (pos(c, d) < LONG_FS) : (c == d - ONE_BIT);
  endfunction : fs_on
  // msb first, 8-bit samples sit in the low byte
  function automatic logic tx_bit(input logic [15:0] s, input logic [4:0] o,
                                  input logic wide);
    logic [4:0] i;
    i = (wide ? W16 : W8) - ONE_BIT - o;
    tx_bit = s[i[3:0]];
  endfunction : tx_bit
  // saturating add so a loud far end cannot wrap to the other sign
  function automatic logic [15:0] sat_add(input logic [15:0] a, b);
    logic [15:0] s;
    s = a + b;
    sat_add = (a[15] == b[15] && s[15] != a[15]) ?
              (a[15] ? 16'h8000 : 16'h7FFF) : s;
  endfunction : sat_add

  cpp_cfg_t cfg_reg, act_reg;
  cpp_dly_t dly_reg;
  cpp_state_t st_reg;
  logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg;
  logic bclk_d_reg, half_reg, fs_last_reg, mclk_reg;
  logic [3:0] div_reg;
  logic [4:0] lcnt_reg, mcnt_reg, lnext, snext, scnt;
  logic s_edge, s_tick, m_tick, l_tick, sp_tick, start, l_frame, run, ch2;
  logic [15:0] rx0_reg, spk_rx_reg, rec_reg, play_reg, ch1_samp, play_nx;
  logic rx_new_reg, under_reg, spk_en;
  logic [31:0] rdata;
  logic setup, wr_acc, rd_acc, tx_push, tx_ready, fifo_v;
  logic [15:0] fifo_q;

  // three-stage pin capture; a change counts once stage 2 and 3 agree
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
      flt_reg <= 4'h0;
    end
    else
    begin
      s1_reg <= {DR2_IN, DR_IN, PRIMARY_FRAME_SYNC_IN, BCLK_IN};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & flt_reg);
    end
  end

  // slave bit clock edge, optionally every second edge
  assign s_edge = flt_reg[0] & ~bclk_d_reg;
  assign s_tick = s_edge & (~act_reg.dual_rate | half_reg);
  assign m_tick = (div_reg == HALF_LAST) & ~mclk_reg;
  assign l_tick = act_reg.master ? m_tick : s_tick;
  assign ch2 = act_reg.spk_ch2;
  assign sp_tick = ch2 ? m_tick : l_tick;
  assign scnt = ch2 ? mcnt_reg : lcnt_reg;
  assign start = act_reg.long_fs ? (flt_reg[1] & ~fs_last_reg) : fs_last_reg;
  assign lnext = (!act_reg.master && start) ? ZERO_BIT : lcnt_reg + ONE_BIT;
  assign snext = ch2 ? mcnt_reg + ONE_BIT : lnext;
  assign l_frame = l_tick & (lnext == ZERO_BIT);
  assign run = st_reg == PS_RUN;
  assign spk_en = act_reg.two_codecs | act_reg.dual_ch;
  // first bit of a frame already carries the sample popped at its start,
  // so a slot at delay 0 on line timing never mixes two samples
  assign play_nx = (l_frame && run) ? (fifo_v ? fifo_q : 16'h0000) :
                   play_reg;
  assign ch1_samp = act_reg.play ? play_nx : 16'h0000;

  // edge history and master divider run free
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      bclk_d_reg <= 1'b0;
      half_reg <= 1'b0;
      div_reg <= 4'h0;
      mclk_reg <= 1'b0;
      mcnt_reg <= ZERO_BIT;
    end
    else
    begin
      bclk_d_reg <= flt_reg[0];
      if (s_edge) half_reg <= ~half_reg;
      div_reg <= (div_reg == HALF_LAST) ? 4'h0 : div_reg + 4'h1;
      if (div_reg == HALF_LAST) mclk_reg <= ~mclk_reg;
      if (m_tick) mcnt_reg <= mcnt_reg + ONE_BIT;
    end
  end

  // line frame counter; slave resyncs on the primary sync
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      lcnt_reg <= LAST_BIT;
      fs_last_reg <= 1'b0;
    end
    else if (l_tick)
    begin
      lcnt_reg <= act_reg.master ? mcnt_reg + ONE_BIT : lnext;
      fs_last_reg <= flt_reg[1];
    end
  end

  // settings latch only between frames or while stopped
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST) act_reg <= CFG_RST;
    else if (!act_reg.en || l_frame) act_reg <= cfg_reg;
  end

  // port state; slave waits for its first frame
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST) st_reg <= PS_OFF;
    else
    begin
      unique case (st_reg)
        PS_OFF: if (act_reg.en) st_reg <= act_reg.master ? PS_RUN : PS_SYNC;
        PS_SYNC: if (!act_reg.en) st_reg <= PS_OFF;
                 else if (l_frame) st_reg <= PS_RUN;
        PS_RUN: if (!act_reg.en) st_reg <= PS_OFF;
        default: st_reg <= PS_OFF;
      endcase
    end
  end

  // pins of the line side; bit clock and sync driven only as master
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      BCLK_OUT <= 1'b0;
      BCLK_OE <= 1'b0;
      PRIMARY_FRAME_SYNC_OUT <= 1'b0;
      PRIMARY_FRAME_SYNC_OE <= 1'b0;
      DX_OUT <= 1'b0;
      DX_OE <= 1'b0;
      rx0_reg <= 16'h0000;
    end
    else
    begin
      BCLK_OUT <= mclk_reg ^ (div_reg == HALF_LAST);
      BCLK_OE <= run & act_reg.master;
      PRIMARY_FRAME_SYNC_OE <= run & act_reg.master;
      if (m_tick) PRIMARY_FRAME_SYNC_OUT <=
          fs_on(mcnt_reg + ONE_BIT, ZERO_BIT, act_reg.long_fs);
      if (l_tick)
      begin
        // channel 0 is the line, channel 1 shares its pins
        if (in_slot(pos(lnext, dly_reg.d0), act_reg.wide))
        begin
          DX_OE <= run;
          DX_OUT <= tx_bit(play_nx, pos(lnext, dly_reg.d0), act_reg.wide);
        end
        else if (!ch2 && spk_en &&
                 in_slot(pos(lnext, dly_reg.d1), act_reg.wide))
        begin
          DX_OE <= run;
          DX_OUT <= tx_bit(ch1_samp, pos(lnext, dly_reg.d1), act_reg.wide);
        end
        else DX_OE <= 1'b0;
        if (in_slot(pos(lcnt_reg, dly_reg.d0), act_reg.wide))
          rx0_reg <= {rx0_reg[14:0], flt_reg[2]};
      end
    end
  end

  // speaker path on ch1 line timing or ch2 master timing
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      FS2_OUT <= 1'b0;
      DX2_OUT <= 1'b0;
      DX2_OE <= 1'b0;
      spk_rx_reg <= 16'h0000;
    end
    else if (sp_tick)
    begin
      FS2_OUT <= run & ch2 & fs_on(snext, dly_reg.d1, act_reg.long_fs);
      DX2_OE <= run & ch2 & in_slot(pos(snext, dly_reg.d1), act_reg.wide);
      DX2_OUT <= tx_bit(ch1_samp, pos(snext, dly_reg.d1), act_reg.wide);
      if (spk_en && in_slot(pos(scnt, dly_reg.d1), act_reg.wide))
        spk_rx_reg <= {spk_rx_reg[14:0], ch2 ? flt_reg[3] : flt_reg[2]};
    end
  end

  // per frame: record sample out, next playback sample in
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rec_reg <= 16'h0000;
      play_reg <= 16'h0000;
      rx_new_reg <= 1'b0;
      under_reg <= 1'b0;
    end
    else
    begin
      if (l_frame && run)
      begin
        // an unconfigured speaker path adds nothing, not a stale sample
        rec_reg <= act_reg.rec ?
                   sat_add(rx0_reg, spk_en ? spk_rx_reg : 16'h0000) :
                   rx0_reg;
        play_reg <= fifo_v ? fifo_q : 16'h0000;
      end
      // a new event wins over a read clearing it
      if (l_frame && run) rx_new_reg <= 1'b1;
      else if (rd_acc && PADDR == A_RX) rx_new_reg <= 1'b0;
      if (l_frame && run && !fifo_v) under_reg <= 1'b1;
      else if (rd_acc && PADDR == A_STAT) under_reg <= 1'b0;
    end
  end

  // playback FIFO; a full FIFO stalls the APB write
  cpp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(tx_push),
    .in_ready(tx_ready),
    .in_data(PWDATA[15:0]),
    .out_valid(fifo_v),
    .out_ready(l_frame & run),
    .out_data(fifo_q)
  );

  // APB decode; read data captured in setup, ready held low on a TX write while full
  assign setup = PSEL & ~PENABLE;
  assign PREADY = !(PWRITE && PADDR == A_TX && !tx_ready);
  assign wr_acc = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_acc = PSEL & PENABLE & PREADY & ~PWRITE;
  assign tx_push = PSEL & PENABLE & PWRITE & (PADDR == A_TX);
  assign PSLVERR = PSEL & PENABLE & !(PADDR inside {A_CTRL, A_DLY, A_TX,
                   A_RX, A_STAT});
  always_comb
  begin
    unique case (PADDR)
      A_CTRL: rdata = {22'h00_0000, cfg_reg};
      A_DLY: rdata = {22'h00_0000, dly_reg};
      A_RX: rdata = {16'h0000, rec_reg};
      A_STAT: rdata = {26'h000_0000, fifo_v, tx_ready, under_reg,
                       rx_new_reg, st_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA <= 32'h0000_0000;
      cfg_reg <= CFG_RST;
      dly_reg <= DLY_RST;
    end
    else
    begin
      if (setup) PRDATA <= rdata;
      if (wr_acc && PADDR == A_CTRL) cfg_reg <= PWDATA[CFG_W-1:0];
      if (wr_acc && PADDR == A_DLY) dly_reg <= PWDATA[CFG_W-1:0];
    end
  end

  property p_cfg_frame;
    @(posedge REF_CLK) disable iff (RST)
    (act_reg != $past(act_reg)) |-> $past(!act_reg.en || l_frame);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame)
    else $error("config changed inside a frame");
  property p_master_clk;
    @(posedge REF_CLK) disable iff (RST)
    (run && act_reg.master) |=> BCLK_OE && PRIMARY_FRAME_SYNC_OE;
  endproperty
  a_master_clk: assert property (p_master_clk)
    else $error("master not driving clock");
  property p_slave_quiet;
    @(posedge REF_CLK) disable iff (RST)
    !act_reg.master |=> !BCLK_OE;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("slave drives bit clock");
  property p_dual;
    @(posedge REF_CLK) disable iff (RST)
    (act_reg.dual_rate && s_edge && !half_reg) |-> !s_tick;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual rate edge not skipped");
  property p_slot;
    @(posedge REF_CLK) disable iff (RST)
    (l_tick && run && pos(lnext, dly_reg.d0) == ZERO_BIT) |=>
    DX_OE && DX_OUT == tx_bit(play_reg, ZERO_BIT, $past(act_reg.wide));
  endproperty
  a_slot: assert property (p_slot)
    else $error("channel 0 slot not at delay");
  property p_sum;
    @(posedge REF_CLK) disable iff (RST)
    (l_frame && run && act_reg.rec) |=>
    rec_reg == sat_add($past(rx0_reg),
                       $past(spk_en) ? $past(spk_rx_reg) : 16'h0000);
  endproperty
  a_sum: assert property (p_sum)
    else $error("record sum wrong");
  property p_play;
    @(posedge REF_CLK) disable iff (RST)
    act_reg.play |-> ch1_samp == play_nx;
  endproperty
  a_play: assert property (p_play)
    else $error("playback not on channel 1");
  property p_ch2;
    @(posedge REF_CLK) disable iff (RST)
    (act_reg.spk_ch2 && !m_tick) |-> !sp_tick;
  endproperty
  a_ch2: assert property (p_ch2)
    else $error("channel 2 not on master timing");
  property p_short_fs;
    @(posedge REF_CLK) disable iff (RST)
    (m_tick && act_reg.master && !act_reg.long_fs) |=>
    PRIMARY_FRAME_SYNC_OUT == (mcnt_reg == LAST_BIT);
  endproperty
  a_short_fs: assert property (p_short_fs)
    else $error("short frame sync misplaced");
  c_run_slave: cover property (@(posedge REF_CLK) disable iff (RST)
    run && !act_reg.master && l_frame);
  c_record: cover property (@(posedge REF_CLK) disable iff (RST)
    run && act_reg.rec && l_frame);
  c_stall: cover property (@(posedge REF_CLK) disable iff (RST)
    PSEL && PENABLE && !PREADY);
endmodule : cpp_top

/* File: cpp_codec_model.sv */
// far side of the codec port: line codec or digital timing source
// assumes pin levels resolved by the bench from the port's output enables
module cpp_codec_model (
  // role and receive pattern
  input wire logic slave_en,
  input wire logic dr_ones,
  // pins as seen at the codec
  input wire logic bclk_dev,
  input wire logic fs_dev,
  input wire logic dx,
  input wire logic dx_oe,
  output logic bclk_src,
  output logic fs_src,
  output logic dr,
  // summary of the last whole frame
  output logic [31:0] f_word,
  output logic [5:0] f_bits,
  output logic [6:0] f_len,
  output logic [6:0] f_fsw,
  output logic [6:0] f_at
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] acc;
  logic [5:0] nbits;
  logic [6:0] len, fsw, at;
  logic [4:0] bit_no;
  logic fs_last;
  wire logic cap_clk = slave_en ? bclk_src : bclk_dev;
  wire logic cap_fs = slave_en ? fs_src : fs_dev;
  // without dr_ones the line changes every bit, so no stale level passes
  assign dr = dr_ones | cap_clk;
  // 1 MHz timing source, short sync in bit 31, still while unselected
  initial
  begin
    bclk_src = 1'b0;
    fs_src = 1'b0;
    bit_no = 5'h00;
    forever
    begin
      #500;
      bclk_src = slave_en & ~bclk_src;
      if (bclk_src)
      begin
        bit_no = bit_no + 5'h01;
        fs_src = (bit_no == 5'h1F);
      end
    end
  end
  // mid-bit sampling: frame length, sync width, slot bits and start
  always @(negedge cap_clk)
  begin
    if (cap_fs && !fs_last)
    begin
      f_word <= acc;
      f_bits <= nbits;
      f_len <= len;
      f_fsw <= fsw;
      f_at <= at;
      acc <= {31'h0000_0000, dx & dx_oe};
      nbits <= {5'h00, dx_oe};
      len <= 7'h01;
      fsw <= 7'h01;
      at <= 7'h00;
    end
    else
    begin
      len <= len + 7'h01;
      fsw <= fsw + {6'h00, cap_fs};
      if (dx_oe)
      begin
        acc <= {acc[30:0], dx};
        nbits <= nbits + 6'h01;
        if (nbits == 6'h00)
          at <= len;
      end
    end
    fs_last <= cap_fs;
  end
endmodule : cpp_codec_model

/* File: cpp_top_tb.sv */
// bench of the codec serial port: APB tests against a codec model
// assumes cpp_pkg, cpp_top and cpp_codec_model compiled before it
module cpp_top_tb import cpp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] NONE = 32'h0000_0000;
  localparam logic [15:0] SAMP = 16'hA5C3;
  logic clk, rst, psel, penable, pwrite, slave_en, dr_ones;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, f_word, r;
  logic pready, pslverr, bclk_out, bclk_oe, fs_out, fs_oe, dx_out, dx_oe;
  logic fs2_out, dx2_out, dx2_oe, bclk_src, fs_src, dr, e;
  logic [5:0] f_bits;
  logic [6:0] f_len, f_fsw, f_at;
  int miscompares, compares, fs2_n, dx2_n, dx2_ones;
  wire logic bclk_pin = bclk_oe ? bclk_out : bclk_src;
  wire logic fs_pin = fs_oe ? fs_out : fs_src;
  cpp_top cpp_top_i (.REF_CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BCLK_IN(bclk_pin), .BCLK_OUT(bclk_out), .BCLK_OE(bclk_oe),
    .PRIMARY_FRAME_SYNC_IN(fs_pin), .PRIMARY_FRAME_SYNC_OUT(fs_out),
    .PRIMARY_FRAME_SYNC_OE(fs_oe), .DR_IN(dr), .DX_OUT(dx_out),
    .DX_OE(dx_oe), .DR2_IN(dr), .FS2_OUT(fs2_out), .DX2_OUT(dx2_out),
    .DX2_OE(dx2_oe));
  cpp_codec_model cpp_codec_model_i (.slave_en(slave_en),
    .dr_ones(dr_ones), .bclk_dev(bclk_pin), .fs_dev(fs_pin),
    .dx(dx_out), .dx_oe(dx_oe), .bclk_src(bclk_src), .fs_src(fs_src),
    .dr(dr), .f_word(f_word), .f_bits(f_bits), .f_len(f_len),
    .f_fsw(f_fsw), .f_at(f_at));
  // 20 MHz reference clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // channel 2 sync pulses seen
  always @(posedge fs2_out)
    fs2_n++;
  // REF_CLK cycles inside a channel 2 slot, and how many of them drove a one
  always @(negedge clk)
  begin
    if (dx2_oe)
      dx2_n++;
    if (dx2_oe && dx2_out)
      dx2_ones++;
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one APB transfer; waits for pready under a bounded count
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp, input string what);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, NONE, x, y);
    check(what, x & m, exp);
  endtask : rd_chk
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // watchdog: the tests take about 0.8 ms
  initial
  begin
    #2_000_000;
    miscompares++;
    complete_run();
  end
  // test sequence
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, slave_en, dr_ones} = 5'h00;
    paddr = 8'h00;
    pwdata = NONE;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(A_CTRL, ALL, NONE, "ctrl reset");
    rd_chk(A_DLY, ALL, NONE, "dly reset");
    rd_chk(A_STAT, ALL, 32'h0000_0010, "stat reset");
    apb(1'b0, 8'h14, ALL, r, e);
    check("unmapped err", 32'(e), 32'h0000_0001);
    check("unmapped data", r, NONE);
    end_test("reset");
    wr(A_DLY, ALL);
    rd_chk(A_DLY, ALL, 32'h0000_03FF, "dly fields");
    wr(A_CTRL, 32'h0000_01FF);
    rd_chk(A_CTRL, ALL, 32'h0000_01FF, "ctrl fields");
    wr(A_DLY, 32'h0000_0200);
    repeat (8) wr(A_TX, 32'h0000_A5C3);
    rd_chk(A_STAT, ALL, 32'h0000_0020, "fifo full");
    end_test("registers");
    // master, wide, speaker on ch1, play; ninth push waits for a pop
    wr(A_CTRL, 32'h0000_0349);
    wr(A_TX, 32'h0000_A5C3);
    repeat (1000) @(posedge clk);
    check("bclk drive", 32'(bclk_oe), 32'h0000_0001);
    check("sync drive", 32'(fs_oe), 32'h0000_0001);
    rd_chk(A_STAT, 32'h0000_0003, 32'h0000_0003, "run");
    check("frame len", 32'(f_len), 32'h0000_0020);
    check("short sync", 32'(f_fsw), 32'h0000_0001);
    check("wide bits", 32'(f_bits), 32'h0000_0020);
    // a short-sync frame in the model opens on the sync bit, which is the
    // last bit of the previous ch1 slot, so the word is rotated by one
    check("both slots", f_word, {SAMP[0], SAMP, SAMP[15:1]});
    check("slot start", 32'(f_at), NONE);
    repeat (3200) @(posedge clk);
    check("underrun data", f_word, NONE);
    rd_chk(A_STAT, 32'h0000_003B, 32'h0000_001B, "underrun");
    end_test("master play");
    // long sync, 8-bit slot at bit 5, line only
    wr(A_CTRL, 32'h0000_0380);
    wr(A_DLY, 32'h0000_0005);
    repeat (8) wr(A_TX, 32'h0000_00C3);
    repeat (1000) @(posedge clk);
    check("long sync", 32'(f_fsw), 32'h0000_0008);
    check("narrow bits", 32'(f_bits), 32'h0000_0008);
    check("narrow data", f_word, 32'h0000_00C3);
    check("delayed slot", 32'(f_at), 32'h0000_0005);
    end_test("long narrow");
    // slave timing, recording of line plus speaker, all ones received
    wr(A_DLY, 32'h0000_0200);
    wr(A_CTRL, 32'h0000_024A);
    slave_en <= 1'b1;
    dr_ones <= 1'b1;
    repeat (2500) @(posedge clk);
    check("slave bclk", 32'(bclk_oe), NONE);
    rd_chk(A_STAT, 32'h0000_0003, 32'h0000_0003, "slave run");
    rd_chk(A_RX, 32'h0000_FFFF, 32'h0000_FFFE, "sum ch1");
    wr(A_CTRL, 32'h0000_0256);
    fs2_n = 0;
    dx2_n = 0;
    dx2_ones = 0;
    repeat (2500) @(posedge clk);
    check("ch2 sync", 32'(fs2_n > 0), 32'h0000_0001);
    check("ch2 slot", 32'(dx2_n > 0), 32'h0000_0001);
    check("ch2 silent", 32'(dx2_ones), NONE);
    rd_chk(A_RX, 32'h0000_FFFF, 32'h0000_FFFE, "sum ch2");
    wr(A_CTRL, 32'h0000_0242);
    repeat (2500) @(posedge clk);
    rd_chk(A_RX, 32'h0000_FFFF, 32'h0000_FFFF, "line only");
    end_test("slave record");
    // slave with every second bit clock edge used
    wr(A_CTRL, 32'h0000_0262);
    repeat (3000) @(posedge clk);
    rd_chk(A_STAT, 32'h0000_0007, 32'h0000_0007, "dual rate run");
    rd_chk(A_RX, 32'h0000_FFFF, 32'h0000_FFFF, "dual rate rx");
    end_test("dual rate");
    complete_run();
  end
endmodule : cpp_top_tb
